// [src/blk_cmd_top.sv]
// block read/write command interpreter for the contactless link
`timescale 1ns/100ps
module blk_cmd_top
    import blkcmd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [63:0] own_id,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    output logic rx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    input wire logic tx_ready
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    state_t state_q, state_d;
    logic [8:0] len_q, len_d, pos_q, pos_d;
    logic [8:0] tx_p_q, tx_p_d, tx_len_q, tx_len_d;
    logic [7:0] k_q, k_d, m_q, m_d, cnt_q, cnt_d, sf2_q, sf2_d;
    logic [7:0] tx_data_q, tx_data_d;
    logic [3:0] bc_q, bc_d;
    logic err_q, err_d, wr_q, wr_d;
    logic rx_ready_q, rx_ready_d, tx_valid_q, tx_valid_d;
    logic tx_last_q, tx_last_d;
    logic [7:0] blk_q [BLK_SLOTS];
    logic [7:0] blk_d [BLK_SLOTS];
    logic [7:0] fbuf [256];

    nv_mem_if mem_bus ();

    nv_block_mem u_mem (
        .clk (clk),
        .port (mem_bus.mem)
    );

    // ------------------------------------------------------------
    // request decode helpers
    // ------------------------------------------------------------
    logic rx_take, is_wr_cmd, hdr_ok, tx_free, entry_short;
    logic [63:0] id_rx;
    logic [7:0] id_b [8];
    logic [7:0] b0, b1, b2, k_max, m_max, tx_byte;
    logic [8:0] entry_len, off;
    logic [15:0] entry_num;
    logic [9:0] data_need;

    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            id_rx[63-8*i -: 8] = fbuf[i+1];
            id_b[i] = own_id[63-8*i -: 8];
        end
    end

    assign rx_take = rx_valid && rx_ready_q;
    assign is_wr_cmd = (fbuf[0] == CMD_WRITE);
    assign hdr_ok = (len_q >= HDR_MIN_LEN) && (id_rx == own_id)
        && ((fbuf[0] == CMD_READ) || is_wr_cmd);
    assign k_max = is_wr_cmd ? WR_K_MAX : RD_K_MAX;
    assign m_max = !wr_q ? RD_M_MAX
        : ((k_q <= WR_K_SPLIT) ? WR_M_MAX_LO : WR_M_MAX_HI);
    assign b0 = fbuf[pos_q[7:0]];
    assign b1 = fbuf[pos_q[7:0] + 8'h01];
    assign b2 = fbuf[pos_q[7:0] + 8'h02];
    assign entry_short = b0[LIST_SHORT_BIT];
    assign entry_len = entry_short ? 9'h002 : 9'h003;
    assign entry_num = entry_short ? {8'h00, b1} : {b2, b1};
    assign data_need = {1'b0, pos_q} + {2'b00, m_q[3:0], 4'h0};
    assign tx_free = !tx_valid_q || tx_ready;
    assign off = tx_p_q - TX_DATA_POS;

    // memory port: write in S_WR, otherwise read for the reply
    assign mem_bus.addr = (state_q == S_WR)
        ? {blk_q[cnt_q[3:0]][4:0], bc_q}
        : {blk_q[off[7:4]][4:0], off[3:0]};
    assign mem_bus.wdata = b0;
    assign mem_bus.we = (state_q == S_WR);

    // reply byte at position tx_p_q
    always_comb
    begin
        tx_byte = mem_bus.rdata;
        if (tx_p_q == 9'h000)
        begin
            tx_byte = wr_q ? RSP_WRITE : RSP_READ;
        end
        else if (tx_p_q <= 9'h008)
        begin
            tx_byte = id_b[3'(tx_p_q - 9'h001)];
        end
        else if (tx_p_q == 9'h009)
        begin
            tx_byte = err_q ? SF1_ERR : SF_OK;
        end
        else if (tx_p_q == 9'h00A)
        begin
            tx_byte = sf2_q;
        end
        else if (tx_p_q == 9'h00B)
        begin
            tx_byte = m_q;
        end
    end

    // ------------------------------------------------------------
    // frame buffer
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rx_take && (len_q < BUF_DEPTH))
        begin
            fbuf[len_q[7:0]] <= rx_data;
        end
    end

    // ------------------------------------------------------------
    // command engine
    // ------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        len_d = len_q;
        pos_d = pos_q;
        k_d = k_q;
        m_d = m_q;
        cnt_d = cnt_q;
        sf2_d = sf2_q;
        bc_d = bc_q;
        err_d = err_q;
        wr_d = wr_q;
        blk_d = blk_q;
        tx_p_d = tx_p_q;
        tx_len_d = tx_len_q;
        tx_valid_d = tx_valid_q;
        tx_data_d = tx_data_q;
        tx_last_d = tx_last_q;
        unique case (state_q)
            S_RECV:
            begin
                if (rx_take)
                begin
                    len_d = (len_q == BUF_DEPTH) ? len_q : len_q + 9'h001;
                    if (rx_last)
                    begin
                        state_d = S_HDR;
                    end
                end
            end
            S_HDR:
            begin
                wr_d = is_wr_cmd;
                k_d = fbuf[K_POS];
                pos_d = SVC_LIST_POS;
                cnt_d = 8'h00;
                err_d = 1'b0;
                sf2_d = SF_OK;
                if (!hdr_ok)
                begin
                    state_d = S_RECV;
                    len_d = 9'h000;
                end
                else if (fbuf[K_POS] < COUNT_MIN || fbuf[K_POS] > k_max)
                begin
                    err_d = 1'b1;
                    sf2_d = SF2_SVC_CNT;
                    state_d = S_TXI;
                end
                else
                begin
                    state_d = S_SVC;
                end
            end
            S_SVC:
            begin
                if (cnt_q == k_q)
                begin
                    m_d = b0;
                    pos_d = pos_q + 9'h001;
                    cnt_d = 8'h00;
                    if (pos_q >= len_q)
                    begin
                        state_d = S_RECV;
                        len_d = 9'h000;
                    end
                    else if (b0 < COUNT_MIN || b0 > m_max)
                    begin
                        err_d = 1'b1;
                        sf2_d = SF2_BLK_CNT;
                        state_d = S_TXI;
                    end
                    else
                    begin
                        state_d = S_BLK;
                    end
                end
                else if (pos_q + 9'h001 >= len_q)
                begin
                    state_d = S_RECV;
                    len_d = 9'h000;
                end
                else if (b0 != fbuf[SVC0_POS] || b1 != fbuf[SVC1_POS])
                begin
                    err_d = 1'b1;
                    sf2_d = SF2_SVC_DIFF;
                    state_d = S_TXI;
                end
                else
                begin
                    pos_d = pos_q + 9'h002;
                    cnt_d = cnt_q + 8'h01;
                end
            end
            S_BLK:
            begin
                if (cnt_q == m_q)
                begin
                    cnt_d = 8'h00;
                    bc_d = 4'h0;
                    if (!wr_q)
                    begin
                        state_d = S_TXI;
                    end
                    else if (data_need > {1'b0, len_q})
                    begin
                        state_d = S_RECV;
                        len_d = 9'h000;
                    end
                    else
                    begin
                        state_d = S_WR;
                    end
                end
                else if (pos_q + entry_len > len_q)
                begin
                    state_d = S_RECV;
                    len_d = 9'h000;
                end
                else if (entry_num >= NUM_BLOCKS)
                begin
                    err_d = 1'b1;
                    sf2_d = SF2_BLK_SPEC;
                    state_d = S_TXI;
                end
                else
                begin
                    blk_d[cnt_q[3:0]] = entry_num[7:0];
                    pos_d = pos_q + entry_len;
                    cnt_d = cnt_q + 8'h01;
                end
            end
            S_WR:
            begin
                pos_d = pos_q + 9'h001;
                bc_d = bc_q + 4'h1;
                if (bc_q == 4'hF)
                begin
                    cnt_d = cnt_q + 8'h01;
                    if (cnt_q == m_q - 8'h01)
                    begin
                        state_d = S_TXI;
                    end
                end
            end
            S_TXI:
            begin
                tx_p_d = 9'h000;
                tx_len_d = (err_q || wr_q) ? RSP_HDR_LEN
                    : TX_DATA_POS + {1'b0, m_q[3:0], 4'h0};
                state_d = S_TX;
            end
            S_TX:
            begin
                if (tx_free)
                begin
                    if (tx_p_q < tx_len_q)
                    begin
                        tx_valid_d = 1'b1;
                        tx_data_d = tx_byte;
                        tx_last_d = (tx_p_q == tx_len_q - 9'h001);
                        tx_p_d = tx_p_q + 9'h001;
                    end
                    else
                    begin
                        tx_valid_d = 1'b0;
                        tx_last_d = 1'b0;
                        state_d = S_RECV;
                        len_d = 9'h000;
                    end
                end
            end
        endcase
        rx_ready_d = (state_d == S_RECV);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= S_RECV;
            len_q <= 9'h000;
            pos_q <= 9'h000;
            k_q <= 8'h00;
            m_q <= 8'h00;
            cnt_q <= 8'h00;
            sf2_q <= 8'h00;
            bc_q <= 4'h0;
            err_q <= 1'b0;
            wr_q <= 1'b0;
            blk_q <= '{default: 8'h00};
            tx_p_q <= 9'h000;
            tx_len_q <= 9'h000;
            rx_ready_q <= 1'b0;
            tx_valid_q <= 1'b0;
            tx_data_q <= 8'h00;
            tx_last_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            len_q <= len_d;
            pos_q <= pos_d;
            k_q <= k_d;
            m_q <= m_d;
            cnt_q <= cnt_d;
            sf2_q <= sf2_d;
            bc_q <= bc_d;
            err_q <= err_d;
            wr_q <= wr_d;
            blk_q <= blk_d;
            tx_p_q <= tx_p_d;
            tx_len_q <= tx_len_d;
            rx_ready_q <= rx_ready_d;
            tx_valid_q <= tx_valid_d;
            tx_data_q <= tx_data_d;
            tx_last_q <= tx_last_d;
        end
    end

    assign rx_ready = rx_ready_q;
    assign tx_valid = tx_valid_q;
    assign tx_data = tx_data_q;
    assign tx_last = tx_last_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_write_only_valid;
        mem_bus.we |-> !err_q && wr_q && pos_q < len_q;
    endproperty
    a_write_only_valid: assert property (p_write_only_valid)
        else $error("memory written outside a validated write");

    property p_silent_on_id;
        state_q == S_HDR && id_rx != own_id
            |=> state_q == S_RECV ##1 !tx_valid_q;
    endproperty
    a_silent_on_id: assert property (p_silent_on_id)
        else $error("reply started for a foreign id");

    property p_svc_cnt_err;
        state_q == S_HDR && hdr_ok && (fbuf[K_POS] == 8'h00
            || fbuf[K_POS] > (is_wr_cmd ? 8'h0B : 8'h0F))
            |=> err_q && sf2_q == 8'hA1 && state_q == S_TXI;
    endproperty
    a_svc_cnt_err: assert property (p_svc_cnt_err)
        else $error("bad service count not flagged A1");

    property p_blk_cnt_err;
        state_q == S_SVC && cnt_q == k_q && pos_q < len_q
            && (b0 == 8'h00 || b0 > (!wr_q ? 8'h0F
                : (k_q < 8'h09 ? 8'h0C : 8'h0B)))
            |=> sf2_q == 8'hA2 && err_q;
    endproperty
    a_blk_cnt_err: assert property (p_blk_cnt_err)
        else $error("bad block count not flagged A2");

    property p_svc_diff;
        state_q == S_SVC && cnt_q < k_q && pos_q + 9'h001 < len_q
            && b0 != fbuf[SVC0_POS] |=> sf2_q == 8'hA3;
    endproperty
    a_svc_diff: assert property (p_svc_diff)
        else $error("differing services not flagged A3");

    property p_first_byte;
        tx_valid_q && tx_p_q == 9'h001
            |-> tx_data_q == (wr_q ? 8'h09 : 8'h07);
    endproperty
    a_first_byte: assert property (p_first_byte)
        else $error("wrong response code");

    property p_short_reply;
        tx_valid_q && tx_last_q && (err_q || wr_q) |-> tx_p_q == 9'h00B;
    endproperty
    a_short_reply: assert property (p_short_reply)
        else $error("error or write reply has wrong length");

    property p_read_len;
        tx_valid_q && tx_last_q && !err_q && !wr_q
            |-> tx_p_q == 9'h00C + {1'b0, m_q[3:0], 4'h0};
    endproperty
    a_read_len: assert property (p_read_len)
        else $error("read reply has wrong length");

    property p_tx_hold;
        tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_data_q);
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("reply byte changed while stalled");

    c_read_ok: cover property (tx_last_q && tx_valid_q && !err_q && !wr_q);
    c_write_ok: cover property (state_q == S_WR ##[1:300] tx_last_q);
    c_err_reply: cover property (tx_last_q && tx_valid_q && err_q);
    c_drop: cover property (state_q == S_HDR && !hdr_ok);

endmodule

// [src/blkcmd_pkg.sv]
// constants and types for the contactless block read/write command interpreter
package blkcmd_pkg;

    // command and response codes
    localparam logic [7:0] CMD_READ = 8'h06;
    localparam logic [7:0] RSP_READ = 8'h07;
    localparam logic [7:0] CMD_WRITE = 8'h08;
    localparam logic [7:0] RSP_WRITE = 8'h09;

    // request layout
    localparam logic [7:0] K_POS = 8'h09;
    localparam logic [7:0] SVC0_POS = 8'h0A;
    localparam logic [7:0] SVC1_POS = 8'h0B;
    localparam logic [8:0] SVC_LIST_POS = 9'h00A;
    localparam logic [8:0] HDR_MIN_LEN = 9'h00A;
    localparam int LIST_SHORT_BIT = 7;

    // count limits
    localparam logic [7:0] COUNT_MIN = 8'h01;
    localparam logic [7:0] RD_K_MAX = 8'h0F;
    localparam logic [7:0] RD_M_MAX = 8'h0F;
    localparam logic [7:0] WR_K_MAX = 8'h0B;
    localparam logic [7:0] WR_K_SPLIT = 8'h08;
    localparam logic [7:0] WR_M_MAX_LO = 8'h0C;
    localparam logic [7:0] WR_M_MAX_HI = 8'h0B;

    // status flags
    localparam logic [7:0] SF_OK = 8'h00;
    localparam logic [7:0] SF1_ERR = 8'hFF;
    localparam logic [7:0] SF2_SVC_CNT = 8'hA1;
    localparam logic [7:0] SF2_BLK_CNT = 8'hA2;
    localparam logic [7:0] SF2_SVC_DIFF = 8'hA3;
    localparam logic [7:0] SF2_BLK_SPEC = 8'hA5;

    // reply layout
    localparam logic [8:0] RSP_HDR_LEN = 9'h00B;
    localparam logic [8:0] TX_DATA_POS = 9'h00C;

    // memory and frame sizes
    localparam int BLOCK_BYTES = 16;
    localparam logic [15:0] NUM_BLOCKS = 16'h0020;
    localparam int MEM_BYTES = 512;
    localparam int ADDR_W = 9;
    localparam logic [8:0] BUF_DEPTH = 9'h100;
    localparam int BLK_SLOTS = 16;

    // ndef layout
    localparam logic [15:0] NDEF_SYSTEM_CODE = 16'h12FC;
    localparam logic [7:0] NDEF_ATTR_BLOCK = 8'h00;
    localparam logic [7:0] NDEF_FIRST_BLOCK = 8'h01;
    localparam logic [7:0] NDEF_LAST_BLOCK = 8'h17;

    typedef enum logic [2:0] {
        S_RECV, S_HDR, S_SVC, S_BLK, S_WR, S_TXI, S_TX
    } state_t;

endpackage

// [src/nv_mem_if.sv]
// byte port between the command engine and the block memory
`timescale 1ns/100ps
interface nv_mem_if;
    import blkcmd_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic we;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctrl (output addr, output we, output wdata, input rdata);
    modport mem (input addr, input we, input wdata, output rdata);
endinterface

// [src/nv_block_mem.sv]
// byte-wide non-volatile block store, 16 bytes per block
`timescale 1ns/100ps
module nv_block_mem
    import blkcmd_pkg::*;
(
    input wire logic clk,
    nv_mem_if.mem port
);

    // block 0 holds ndef attributes, blocks 1..23 the ndef file
    logic [7:0] cells [MEM_BYTES];

    always_ff @(posedge clk)
    begin
        if (port.we)
        begin
            cells[port.addr] <= port.wdata;
        end
    end

    assign port.rdata = cells[port.addr];

endmodule

// [test/rw_model.sv]
// reader/writer model: builds request frames and collects replies
`timescale 1ns/100ps
module rw_model
    import blkcmd_pkg::*;
(
    input wire logic clk,
    input wire logic [63:0] tag_id,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready
);
    logic [7:0] fr[$];
    logic [7:0] reply[$];
    logic done;
    logic slow;
    logic [15:0] sys_code = NDEF_SYSTEM_CODE;

    initial
    begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_last = 1'b0;
        tx_ready = 1'b0;
        done = 1'b0;
        slow = 1'b0;
    end

    // ----------------------------------------
    // frame building
    // ----------------------------------------
    task head(input logic [7:0] code, input int k, input bit diff);
        fr.delete();
        fr.push_back(code);
        for (int i = 7; i >= 0; i--)
            fr.push_back(tag_id[i*8 +: 8]);
        fr.push_back(8'(k));
        for (int i = 0; i < k; i++)
        begin
            fr.push_back(8'h09);
            fr.push_back((diff && i == k - 1) ? 8'h01 : 8'h00);
        end
    endtask

    // entries alternate two-byte and three-byte forms
    task list(input logic [7:0] blk[$], input int m);
        fr.push_back(8'(m));
        foreach (blk[i])
        begin
            fr.push_back(i % 2 == 0 ? 8'h80 : 8'h00);
            fr.push_back(blk[i]);
            if (i % 2 == 1)
                fr.push_back(8'h00);
        end
    endtask

    // block data, 16 bytes, block 0 of the user area is ordinary here
    task data(input logic [7:0] b, input logic [7:0] salt);
        for (int j = 0; j < 16; j++)
            fr.push_back({b[3:0], 4'(j)} ^ salt);
    endtask

    // ----------------------------------------
    // request stream and reply sink
    // ----------------------------------------
    task send(output bit ok);
        int n;
        ok = 1'b1;
        reply.delete();
        done = 1'b0;
        foreach (fr[i])
        begin
            rx_valid = 1'b1;
            rx_data = fr[i];
            rx_last = (i == fr.size() - 1);
            n = 0;
            while (rx_ready !== 1'b1 && n < 400)
            begin
                @(posedge clk);
                #1;
                n++;
            end
            ok = ok && (n < 400);
            @(posedge clk);
            #1;
        end
        rx_valid = 1'b0;
        rx_last = 1'b0;
        rx_data = ~rx_data;
    endtask

    always @(posedge clk)
    begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1)
        begin
            reply.push_back(tx_data);
            if (tx_last === 1'b1)
                done <= 1'b1;
        end
        #1;
        tx_ready = slow ? ~tx_ready : 1'b1;
    end
endmodule

// [test/tb.sv]
// self-checking bench for the block read/write command interpreter
`timescale 1ns/100ps
module tb;
    import blkcmd_pkg::*;
    // arbitrary identifier value
    localparam logic [63:0] TAG_ID = 64'h1234_5678_9ABC_DEF0;
    logic clk;
    logic rst;
    logic [63:0] own_id;
    logic [63:0] req_id;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_last;
    logic rx_ready;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_last;
    logic tx_ready;
    int n_mismatch;
    int check_count;
    logic [7:0] salt[32];
    logic [7:0] blk[$];

    blk_cmd_top i_dut (.clk(clk), .rst(rst), .own_id(own_id),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_last(tx_last), .tx_ready(tx_ready));
    rw_model i_rdr (.clk(clk), .tag_id(req_id), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_ready(tx_ready));

    always #2.5 clk = ~clk;

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task check(input string what, input logic [15:0] exp,
               input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task finish_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task req(input logic [7:0] code, input int k, input bit diff,
             input int m, input logic [7:0] s);
        bit ok;
        i_rdr.head(code, k, diff);
        i_rdr.list(blk, m);
        if (code == CMD_WRITE)
            foreach (blk[i])
                i_rdr.data(blk[i], s);
        i_rdr.send(ok);
        if (!ok)
        begin
            check("request taken", 16'h0001, 16'h0000);
            finish_test();
        end
    endtask

    task run(input logic [7:0] code, input int k, input bit diff,
             input int m, input logic [7:0] s);
        int n;
        req(code, k, diff, m, s);
        n = 0;
        while (i_rdr.done !== 1'b1 && n < 3000)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 3000)
        begin
            check("reply done", 16'h0001, 16'h0000);
            finish_test();
        end
        @(posedge clk);
        #1;
    endtask

    task hdr(input logic [7:0] code, input logic [7:0] sf2, input int len);
        check("length", 16'(len), 16'(i_rdr.reply.size()));
        check("code", code, i_rdr.reply[0]);
        for (int i = 0; i < 8; i++)
            check("id", own_id[(7-i)*8 +: 8], i_rdr.reply[i+1]);
        check("flag1", sf2 == SF_OK ? SF_OK : SF1_ERR, i_rdr.reply[9]);
        check("flag2", sf2, i_rdr.reply[10]);
    endtask

    task rd_data;
        check("count", 16'(blk.size()), i_rdr.reply[11]);
        foreach (blk[i])
            for (int j = 0; j < 16; j++)
                check("data", {blk[i][3:0], 4'(j)} ^ salt[blk[i]],
                      i_rdr.reply[12+16*i+j]);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_rw_ok;
        blk = '{8'h01, 8'h03};
        run(CMD_WRITE, 1, 1'b0, 2, 8'h5A);
        hdr(RSP_WRITE, SF_OK, 11);
        salt[1] = 8'h5A;
        salt[3] = 8'h5A;
        i_rdr.slow = 1'b1;
        blk = '{8'h03, 8'h01};
        run(CMD_READ, 2, 1'b0, 2, 8'h00);
        i_rdr.slow = 1'b0;
        hdr(RSP_READ, SF_OK, 44);
        rd_data();
    endtask

    task t_counts;
        blk = '{8'h01};
        run(CMD_READ, 0, 1'b0, 1, 8'h00);
        hdr(RSP_READ, SF2_SVC_CNT, 11);
        run(CMD_READ, 16, 1'b0, 1, 8'h00);
        hdr(RSP_READ, SF2_SVC_CNT, 11);
        run(CMD_WRITE, 12, 1'b0, 1, 8'h33);
        hdr(RSP_WRITE, SF2_SVC_CNT, 11);
        run(CMD_READ, 1, 1'b0, 0, 8'h00);
        hdr(RSP_READ, SF2_BLK_CNT, 11);
        blk.delete();
        for (int i = 0; i < 16; i++)
            blk.push_back(8'h01);
        run(CMD_READ, 1, 1'b0, 16, 8'h00);
        hdr(RSP_READ, SF2_BLK_CNT, 11);
        blk.delete();
        for (int i = 0; i < 12; i++)
            blk.push_back(8'h01);
        run(CMD_WRITE, 9, 1'b0, 12, 8'h77);
        hdr(RSP_WRITE, SF2_BLK_CNT, 11);
        blk = '{8'h01, 8'h28};
        run(CMD_WRITE, 1, 1'b0, 2, 8'h66);
        hdr(RSP_WRITE, SF2_BLK_SPEC, 11);
        blk = '{8'h01};
        run(CMD_READ, 1, 1'b0, 1, 8'h00);
        hdr(RSP_READ, SF_OK, 28);
        rd_data();
    endtask

    task t_max;
        blk = '{8'h02};
        for (int i = 4; i < 15; i++)
            blk.push_back(8'(i));
        run(CMD_WRITE, 8, 1'b0, 12, 8'hC3);
        hdr(RSP_WRITE, SF_OK, 11);
        foreach (blk[i])
            salt[blk[i]] = 8'hC3;
        blk = '{8'h03};
        for (int i = 1; i < 15; i++)
            blk.push_back(8'(i));
        run(CMD_READ, 15, 1'b0, 15, 8'h00);
        hdr(RSP_READ, SF_OK, 252);
        rd_data();
    endtask

    task t_svc_diff;
        blk = '{8'h01};
        run(CMD_READ, 3, 1'b1, 1, 8'h00);
        hdr(RSP_READ, SF2_SVC_DIFF, 11);
        run(CMD_WRITE, 2, 1'b1, 1, 8'h99);
        hdr(RSP_WRITE, SF2_SVC_DIFF, 11);
    endtask

    // foreign id read, then a write whose data is missing
    task t_silent;
        logic seen;
        bit ok;
        blk = '{8'h01};
        for (int f = 0; f < 2; f++)
        begin
            seen = 1'b0;
            req_id = (f == 0) ? ~TAG_ID : TAG_ID;
            @(posedge clk);
            #1;
            i_rdr.head(f == 0 ? CMD_READ : CMD_WRITE, 1, 1'b0);
            i_rdr.list(blk, 1);
            i_rdr.send(ok);
            if (!ok)
            begin
                check("request taken", 16'h0001, 16'h0000);
                finish_test();
            end
            for (int i = 0; i < 60; i++)
            begin
                @(posedge clk);
                if (tx_valid !== 1'b0)
                    seen = 1'b1;
            end
            #1;
            check("silent", 16'h0000, 16'(seen));
            check("ready", 16'h0001, 16'(rx_ready));
        end
        run(CMD_READ, 1, 1'b0, 1, 8'h00);
        hdr(RSP_READ, SF_OK, 28);
        rd_data();
    endtask

    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        own_id = TAG_ID;
        req_id = TAG_ID;
        n_mismatch = 0;
        check_count = 0;
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b0;
        @(posedge clk);
        #1;
        t_rw_ok();
        t_counts();
        t_max();
        t_svc_diff();
        t_silent();
        finish_test();
    end
endmodule
